// ==== rtl/lcfs_regs.vh ====
// Register map, field positions and timing constants of the fade sequencer.
`ifndef LCFS_REGS_VH
`define LCFS_REGS_VH

// ****************************************************************
// Register addresses carried in bits 14..8 of the serial word
// ****************************************************************
`define LCFS_ADDR_CFG 7'h10
`define LCFS_ADDR_FADE 7'h11
`define LCFS_ADDR_RAMP 7'h12
`define LCFS_ADDR_GLOBAL 7'h15

// ****************************************************************
// Serial word layout
// ****************************************************************
`define LCFS_WORD_W 16
`define LCFS_RW_BIT 15
`define LCFS_ADDR_MSB 14
`define LCFS_ADDR_LSB 8
`define LCFS_DATA_MSB 7

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define LCFS_CFG_RUN 0
`define LCFS_CFG_CSWAKE 1
`define LCFS_CFG_RAMPEN 2
`define LCFS_CFG_ST_HOLD 3
`define LCFS_CFG_ST_FADE 4
`define LCFS_CFG_ST_RAMP 5
`define LCFS_CFG_OSC 7

// ****************************************************************
// Ramp-down register fields and reset values
// ****************************************************************
`define LCFS_FADE_MSB 2
`define LCFS_FADE_LSB 0
`define LCFS_HOLD_MSB 5
`define LCFS_HOLD_LSB 3
`define LCFS_FADE_RST 6'h00
`define LCFS_RAMP_RST 3'h0
`define LCFS_GLOBAL_RST 3'h7
`define LCFS_DAC_FULL 3'h7
`define LCFS_DAC_ZERO 3'h0
`define LCFS_CODE_OFF 3'h0

// ****************************************************************
// Timing: clock rate, PWM rate and time units
// ****************************************************************
`define LCFS_CLK_HZ 32'h0262_5A00
`define LCFS_PWM_HZ 32'h0000_8000
`define LCFS_UNIT_DIV 32'h0000_0010
`define LCFS_STEPS 32'h0000_0008
`define LCFS_WAKE_US 32'h0000_0BB8
`define LCFS_US_PER_S 32'h000F_4240

`endif

// ==== rtl/lcfs_sync.v ====
// Two flip-flop synchroniser for one asynchronous input.
`timescale 1ns/1ps
`default_nettype none
module lcfs_sync #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire d_i,
  output reg q_o
);

  reg meta;

  // The first stage feeds only the second stage.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/lcfs_top.v ====
// Serial slave port and shutdown fade / wake ramp sequencer.
//
// Notes on behaviour
// - Ramp-down bits 2..0 select fade-off time.
// - Ramp-down bits 5..3 select hold-off delay.
// - Shutdown runs hold-off, then fade-off, then stops.
// - Ramp-up bits 2..0 select wake ramp time.
// - Hold, fade and ramp durations counted in PWM clock periods; the wake select-low time in system clock cycles.
// - Internal oscillator runs throughout a fade sequence unless the external clock is selected.
// - Ramp steps a 3-bit master reference DAC.
// - Global current level caps the ramp DAC.
// - Config register shows hold, fade, ramp status.
// - One config write starts shutdown and options.
// - Data shifted on rising clock, select low.
// - Serial output is driven unless the external clock is selected.
// - Clock and data ignored while select high.
// - Word is command byte then data byte.
// - Hold-off keeps outputs at full current.
// - Bit 15 read/write, bits 14..8 address.
// - Only last sixteen bits latched at select rise.
// - Read loads register into low shift byte.
`timescale 1ns/1ps
`include "lcfs_regs.vh"
`default_nettype none
module lcfs_top #(
  parameter [19:0] WAKE_CYC = 20'h1_D4C0
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire din_i,
  input wire serial_out_or_pwm_clock_pin_i,
  output wire serial_out_or_pwm_clock_pin_o,
  output wire serial_out_or_pwm_clock_pin_oe_o,
  output reg [2:0] current_dac_o,
  output wire shutdown_o,
  output wire pwm_osc_run_o
);

  // ****************************************************************
  // Constants derived from the clock and PWM rates
  // ****************************************************************
  localparam [31:0] DIV_FULL = `LCFS_CLK_HZ / `LCFS_PWM_HZ;
  localparam [10:0] DIV_LAST = DIV_FULL[10:0] - 11'h001;
  localparam [31:0] UNIT_FULL = `LCFS_PWM_HZ / `LCFS_UNIT_DIV;
  localparam [17:0] HOLD_UNIT = UNIT_FULL[17:0];
  localparam [31:0] STEP_FULL = UNIT_FULL / `LCFS_STEPS;
  localparam [17:0] STEP_UNIT = STEP_FULL[17:0];
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_HOLD = 3'h1;
  localparam [2:0] ST_FADE = 3'h2;
  localparam [2:0] ST_SHDN = 3'h3;
  localparam [2:0] ST_RAMP = 3'h4;

  // Duration in PWM periods: the unit doubled per code step above one.
  function [17:0] lcfs_len;
    input [2:0] code;
    input [17:0] unit;
    begin
      lcfs_len = unit << (code - 3'h1);
    end
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  wire sclk_q;
  wire cs_n_q;
  wire din_q;
  wire ext_q;

  lcfs_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(sclk_i),
    .q_o(sclk_q)
  );
  lcfs_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(cs_n_i),
    .q_o(cs_n_q)
  );
  lcfs_sync #(.RST_VAL(1'b0)) u_sync_din (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(din_i),
    .q_o(din_q)
  );
  lcfs_sync #(.RST_VAL(1'b0)) u_sync_ext (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(serial_out_or_pwm_clock_pin_i),
    .q_o(ext_q)
  );

  // ****************************************************************
  // Edge detection on the synchronised pins
  // ****************************************************************
  reg sclk_d;
  reg cs_n_d;
  reg ext_d;

  // Previous values for edge finding.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      ext_d <= 1'b0;
    end else begin
      sclk_d <= sclk_q;
      cs_n_d <= cs_n_q;
      ext_d <= ext_q;
    end
  end

  // Clock edges count only while select is low.
  wire sclk_rise = sclk_q & ~sclk_d & ~cs_n_q;
  wire sclk_fall = ~sclk_q & sclk_d & ~cs_n_q;
  wire cs_rise = cs_n_q & ~cs_n_d;
  wire cs_fall = ~cs_n_q & cs_n_d;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [`LCFS_WORD_W-1:0] shreg;
  reg dout;
  reg [5:0] fade_timing;
  reg [2:0] wake_ramp;
  reg [2:0] global_level;
  reg cfg_run;
  reg cfg_cswake;
  reg cfg_rampen;
  reg cfg_osc;
  reg [2:0] state;
  reg [2:0] dac;
  reg [17:0] cnt;
  reg [10:0] div_cnt;
  reg [19:0] wake_cnt;
  reg [7:0] rd_data;

  wire [6:0] addr = shreg[`LCFS_ADDR_MSB:`LCFS_ADDR_LSB];
  wire [7:0] wdata = shreg[`LCFS_DATA_MSB:0];
  wire is_read = shreg[`LCFS_RW_BIT];
  wire wr_stb = cs_rise & ~is_read;
  wire cfg_wr = wr_stb & (addr == `LCFS_ADDR_CFG);
  wire [2:0] fade_code = fade_timing[`LCFS_FADE_MSB:`LCFS_FADE_LSB];
  wire [2:0] hold_code = fade_timing[`LCFS_HOLD_MSB:`LCFS_HOLD_LSB];

  // Status follows the state, so a skipped phase never shows.
  wire st_hold = (state == ST_HOLD);
  wire st_fade = (state == ST_FADE);
  wire st_ramp = (state == ST_RAMP);

  // Read multiplexer; unused bits return zero.
  always @* begin
    rd_data = 8'h00;
    case (addr)
      `LCFS_ADDR_CFG: begin
        rd_data[`LCFS_CFG_RUN] = cfg_run;
        rd_data[`LCFS_CFG_CSWAKE] = cfg_cswake;
        rd_data[`LCFS_CFG_RAMPEN] = cfg_rampen;
        rd_data[`LCFS_CFG_ST_HOLD] = st_hold;
        rd_data[`LCFS_CFG_ST_FADE] = st_fade;
        rd_data[`LCFS_CFG_ST_RAMP] = st_ramp;
        rd_data[`LCFS_CFG_OSC] = cfg_osc;
      end
      `LCFS_ADDR_FADE: rd_data = {2'h0, fade_timing};
      `LCFS_ADDR_RAMP: rd_data = {5'h00, wake_ramp};
      `LCFS_ADDR_GLOBAL: rd_data = {5'h00, global_level};
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Serial shift register and data output
  // ****************************************************************
  // The shifter keeps running past sixteen bits, so whatever is in it
  // at select rise is the last sixteen bits received.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shreg <= 16'h0000;
      dout <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shreg <= {shreg[`LCFS_WORD_W-2:0], din_q};
      end else if (cs_rise && is_read) begin
        shreg[`LCFS_DATA_MSB:0] <= rd_data;
      end
      if (sclk_fall || cs_fall) begin
        dout <= shreg[`LCFS_WORD_W-1];
      end
    end
  end

  // The pin is driven whenever it is the data output, selected or not.
  assign serial_out_or_pwm_clock_pin_o = dout;
  assign serial_out_or_pwm_clock_pin_oe_o = ~cfg_osc;

  // ****************************************************************
  // PWM time base
  // ****************************************************************
  // The internal divider runs in every state but shutdown unless the external
  // clock is selected, so a fade is timed even when no port uses PWM.
  assign pwm_osc_run_o = (state != ST_SHDN) & ~cfg_osc;
  wire int_tick = pwm_osc_run_o & (div_cnt == DIV_LAST);
  // An external clock that stops mid-sequence simply freezes it.
  wire pwm_tick = cfg_osc ? (ext_q & ~ext_d) : int_tick;

  // Divider from the system clock down to the PWM rate.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt <= 11'h000;
    end else if (!pwm_osc_run_o || int_tick) begin
      div_cnt <= 11'h000;
    end else begin
      div_cnt <= div_cnt + 11'h001;
    end
  end

  // ****************************************************************
  // Wake on a long select-low pulse
  // ****************************************************************
  wire cs_wake = cfg_cswake & (state == ST_SHDN) & (wake_cnt == WAKE_CYC);

  // Counts system cycles with select held low during shutdown.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_cnt <= 20'h0_0000;
    end else if (cs_n_q || state != ST_SHDN) begin
      wake_cnt <= 20'h0_0000;
    end else if (wake_cnt != WAKE_CYC) begin
      wake_cnt <= wake_cnt + 20'h0_0001;
    end
  end

  wire sd_req = cfg_wr & ~wdata[`LCFS_CFG_RUN];
  wire run_req = (cfg_wr & wdata[`LCFS_CFG_RUN]) | cs_wake;
  wire use_ramp = (cfg_wr ? wdata[`LCFS_CFG_RAMPEN] : cfg_rampen) &
                  (wake_ramp != `LCFS_CODE_OFF);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fade_timing <= `LCFS_FADE_RST;
      wake_ramp <= `LCFS_RAMP_RST;
      global_level <= `LCFS_GLOBAL_RST;
      cfg_run <= 1'b1;
      cfg_cswake <= 1'b0;
      cfg_rampen <= 1'b0;
      cfg_osc <= 1'b0;
    end else begin
      if (wr_stb && addr == `LCFS_ADDR_FADE) begin
        fade_timing <= wdata[`LCFS_HOLD_MSB:0];
      end
      if (wr_stb && addr == `LCFS_ADDR_RAMP) begin
        wake_ramp <= wdata[`LCFS_FADE_MSB:0];
      end
      if (wr_stb && addr == `LCFS_ADDR_GLOBAL) begin
        global_level <= wdata[`LCFS_FADE_MSB:0];
      end
      // One write sets run, wake enable and ramp enable together.
      if (cfg_wr) begin
        cfg_run <= wdata[`LCFS_CFG_RUN];
        cfg_cswake <= wdata[`LCFS_CFG_CSWAKE];
        cfg_rampen <= wdata[`LCFS_CFG_RAMPEN];
        cfg_osc <= wdata[`LCFS_CFG_OSC];
      end else if (cs_wake) begin
        cfg_run <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Fade sequencer
  // ****************************************************************
  // Fade and ramp each take seven DAC steps over eight equal intervals of the set time.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_RUN;
      dac <= `LCFS_DAC_FULL;
      cnt <= 18'h0_0000;
    end else begin
      case (state)
        ST_RUN: begin
          dac <= `LCFS_DAC_FULL;
          if (sd_req) begin
            if (hold_code != `LCFS_CODE_OFF) begin
              state <= ST_HOLD;
              cnt <= lcfs_len(hold_code, HOLD_UNIT) - 18'h0_0001;
            end else if (fade_code != `LCFS_CODE_OFF) begin
              state <= ST_FADE;
              cnt <= lcfs_len(fade_code, STEP_UNIT) - 18'h0_0001;
            end else begin
              state <= ST_SHDN;
              dac <= `LCFS_DAC_ZERO;
            end
          end
        end
        ST_HOLD: begin
          dac <= `LCFS_DAC_FULL;
          if (run_req) begin
            state <= ST_RUN;
          end else if (pwm_tick) begin
            if (cnt != 18'h0_0000) begin
              cnt <= cnt - 18'h0_0001;
            end else if (fade_code != `LCFS_CODE_OFF) begin
              state <= ST_FADE;
              cnt <= lcfs_len(fade_code, STEP_UNIT) - 18'h0_0001;
            end else begin
              state <= ST_SHDN;
              dac <= `LCFS_DAC_ZERO;
            end
          end
        end
        ST_FADE: begin
          if (run_req) begin
            state <= ST_RUN;
            dac <= `LCFS_DAC_FULL;
          end else if (pwm_tick) begin
            if (cnt != 18'h0_0000) begin
              cnt <= cnt - 18'h0_0001;
            end else if (dac == `LCFS_DAC_ZERO) begin
              state <= ST_SHDN;
            end else begin
              dac <= dac - 3'h1;
              cnt <= lcfs_len(fade_code, STEP_UNIT) - 18'h0_0001;
            end
          end
        end
        ST_SHDN: begin
          dac <= `LCFS_DAC_ZERO;
          if (run_req) begin
            if (use_ramp) begin
              state <= ST_RAMP;
              cnt <= lcfs_len(wake_ramp, STEP_UNIT) - 18'h0_0001;
            end else begin
              state <= ST_RUN;
              dac <= `LCFS_DAC_FULL;
            end
          end
        end
        ST_RAMP: begin
          if (sd_req) begin
            state <= ST_SHDN;
            dac <= `LCFS_DAC_ZERO;
          end else if (pwm_tick) begin
            if (cnt != 18'h0_0000) begin
              cnt <= cnt - 18'h0_0001;
            end else if (dac == `LCFS_DAC_FULL) begin
              state <= ST_RUN;
            end else begin
              dac <= dac + 3'h1;
              cnt <= lcfs_len(wake_ramp, STEP_UNIT) - 18'h0_0001;
            end
          end
        end
        default: begin
          state <= ST_RUN;
          dac <= `LCFS_DAC_FULL;
        end
      endcase
    end
  end

  // The global level clips the ramp, so with a low global setting the
  // output follows the ramp until it rises past that level, then holds flat.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      current_dac_o <= `LCFS_DAC_FULL;
    end else begin
      current_dac_o <= (dac < global_level) ? dac : global_level;
    end
  end

  assign shutdown_o = (state == ST_SHDN);

endmodule
`default_nettype wire

// ==== sim/lcfs_host_model.sv ====
// Host-side serial master that frames words onto the four-wire port.
`timescale 1ns/1ps
`default_nettype none
module lcfs_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // ****
  // Link clock and framing
  // ****
  // Clock rests low and select high between frames.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Half of the 200 ns link clock period.
  task half;
    repeat (4) @(posedge clk_i);
  endtask
  // Shifts the low n bits of w MSB first; sel low leaves select high.
  task xfer(input logic [31:0] w, input int n, input logic sel,
            output logic [15:0] rx);
    int i;
    cs_n_o <= ~sel;
    half;
    for (i = n - 1; i >= 0; i--) begin
      din_o <= w[i];
      half;
      sclk_o <= 1'b1;
      rx = {rx[14:0], sdo_i};
      half;
      sclk_o <= 1'b0;
    end
    // Released data shows the inverse so a stale bit is never trusted.
    din_o <= ~din_o;
    half;
    cs_n_o <= 1'b1;
    half;
    half;
  endtask
endmodule
`default_nettype wire

// ==== sim/lcfs_top_checker.sv ====
// Port-level assertions for the fade sequencer and its serial port.
`timescale 1ns/1ps
`default_nettype none
module lcfs_top_checker #(
  parameter [19:0] WAKE_CYC = 20'h1_D4C0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_out_or_pwm_clock_pin_o,
  input wire logic serial_out_or_pwm_clock_pin_oe_o,
  input wire logic [2:0] current_dac_o,
  input wire logic shutdown_o,
  input wire logic pwm_osc_run_o
);
  // ****
  // Helper logic
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic sclk_q;
  logic cs_q;
  logic [3:0] age;
  logic [19:0] lowcnt;
  // Age since the last pin-level clock or select fall; select-low run length.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      age <= 4'hF;
      lowcnt <= 20'h0_0000;
    end else begin
      sclk_q <= sclk_i;
      cs_q <= cs_n_i;
      if ((sclk_q && !sclk_i) || (cs_q && !cs_n_i)) begin
        age <= 4'h0;
      end else if (age != 4'hF) begin
        age <= age + 4'h1;
      end
      if (cs_n_i) begin
        lowcnt <= 20'h0_0000;
      end else if (lowcnt != 20'hF_FFFF) begin
        lowcnt <= lowcnt + 20'h0_0001;
      end
    end
  end
  property p_shdn_dac;
    shutdown_o && $past(shutdown_o) |-> current_dac_o == 3'h0;
  endproperty
  a_shdn_dac: assert property (p_shdn_dac)
    else $error("dac not zero in shutdown");
  property p_dac_frozen;
    $changed(current_dac_o) |-> !($past(shutdown_o) && $past(shutdown_o, 2));
  endproperty
  a_dac_frozen: assert property (p_dac_frozen)
    else $error("dac moved while shut down");
  property p_run_osc;
    !shutdown_o && serial_out_or_pwm_clock_pin_oe_o |-> pwm_osc_run_o;
  endproperty
  a_run_osc: assert property (p_run_osc)
    else $error("internal oscillator stopped while awake");
  property p_osc_off_shdn;
    shutdown_o |-> !pwm_osc_run_o;
  endproperty
  a_osc_off_shdn: assert property (p_osc_off_shdn)
    else $error("internal oscillator running in shutdown");
  property p_osc_off_ext;
    !serial_out_or_pwm_clock_pin_oe_o |-> !pwm_osc_run_o;
  endproperty
  a_osc_off_ext: assert property (p_osc_off_ext)
    else $error("internal oscillator running with external clock");
  property p_dout_quiet;
    cs_n_i [*6] |-> $stable(serial_out_or_pwm_clock_pin_o);
  endproperty
  a_dout_quiet: assert property (p_dout_quiet)
    else $error("data out moved while deselected");
  property p_oe_idle;
    $changed(serial_out_or_pwm_clock_pin_oe_o) |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output enable changed inside a frame");
  property p_dout_edge;
    $changed(serial_out_or_pwm_clock_pin_o) |-> age <= 4'h7;
  endproperty
  a_dout_edge: assert property (p_dout_edge)
    else $error("data out changed away from a clock fall");
  property p_wake_cause;
    $fell(shutdown_o) |-> lowcnt == 20'h0_0000 || lowcnt >= WAKE_CYC;
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake on a short select pulse");
  c_fade: cover property ($rose(shutdown_o));
  c_wake: cover property ($fell(shutdown_o));
  c_ext: cover property ($fell(serial_out_or_pwm_clock_pin_oe_o));
  c_cap: cover property (current_dac_o == 3'h3);
endmodule
bind lcfs_top lcfs_top_checker #(.WAKE_CYC(WAKE_CYC)) chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .serial_out_or_pwm_clock_pin_o(serial_out_or_pwm_clock_pin_o),
  .serial_out_or_pwm_clock_pin_oe_o(serial_out_or_pwm_clock_pin_oe_o),
  .current_dac_o(current_dac_o), .shutdown_o(shutdown_o),
  .pwm_osc_run_o(pwm_osc_run_o));
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the fade sequencer and its serial port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****
  // Clock, pins and instances
  // ****
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sclk;
  logic cs_n;
  logic din;
  logic pin_o;
  logic oe;
  logic shdn;
  logic osc_run;
  logic [2:0] dac;
  logic [2:0] ph = 3'h0;
  logic [15:0] rx;
  logic [7:0] rv;
  logic [2:0] prev;
  int n_mismatch = 0;
  int checks = 0;
  int t;
  int steps;
  // The external PWM clock runs at one eighth of the system clock.
  wire logic pin = oe ? pin_o : ph[2];
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) ph <= ph + 3'h1;
  lcfs_host_model host (.clk_i(clk_i), .sdo_i(pin), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din));
  lcfs_top #(.WAKE_CYC(20'h0_0014)) DUT (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .serial_out_or_pwm_clock_pin_i(pin),
    .serial_out_or_pwm_clock_pin_o(pin_o),
    .serial_out_or_pwm_clock_pin_oe_o(oe), .current_dac_o(dac),
    .shutdown_o(shdn), .pwm_osc_run_o(osc_run));
  // ****
  // Access and compare tasks
  // ****
  task cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task cmpr(input string nm, input int lo, input int hi, input int s);
    checks++;
    if (s < lo || s > hi) begin
      n_mismatch++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({16'h0000, 1'b0, a, d}, 16, 1'b1, rx);
  endtask
  // A read needs a second frame; its first byte echoes the command.
  task chk(input logic [6:0] a, input logic [7:0] e);
    host.xfer({16'h0000, 1'b1, a, 8'h00}, 16, 1'b1, rx);
    host.xfer(32'h0000_9000, 16, 1'b1, rx);
    cmp8("echo", {1'b1, a}, rx[15:8]);
    cmp8("reg", e, rx[7:0]);
  endtask
  task pins(input logic [7:0] e);
    cmp8("pins", e, {2'b00, dac, oe, shdn, osc_run});
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized above the bounded fade and ramp waits plus all frames,
  // yet short enough that a hang still ends the run promptly.
  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish;
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    pins(8'h3D);
    chk(7'h11, 8'h00);
    chk(7'h12, 8'h00);
    chk(7'h15, 8'h07);
    chk(7'h10, 8'h01);
    chk(7'h20, 8'h00);
    wr(7'h11, 8'hFF);
    wr(7'h12, 8'hFF);
    chk(7'h11, 8'h3F);
    chk(7'h12, 8'h07);
    host.xfer(32'h0000_1100, 16, 1'b0, rx);
    chk(7'h11, 8'h3F);
    host.xfer(32'h00AA_1105, 24, 1'b1, rx);
    chk(7'h11, 8'h05);
    wr(7'h15, 8'h03);
    pins(8'h1D);
    wr(7'h15, 8'h07);
    // Long internal hold-off: sample status, then abort back to full.
    wr(7'h11, 8'h08);
    wr(7'h10, 8'h00);
    chk(7'h10, 8'h08);
    pins(8'h3D);
    wr(7'h10, 8'h01);
    chk(7'h10, 8'h01);
    // Zero timings shut down at once; a long select pulse wakes it.
    wr(7'h11, 8'h00);
    wr(7'h10, 8'h02);
    pins(8'h06);
    wr(7'h7F, 8'h00);
    pins(8'h3D);
    // External clock: one tick per eight clocks makes the times exact.
    wr(7'h11, 8'h09);
    wr(7'h12, 8'h01);
    wr(7'h10, 8'h84);
    t = 0;
    steps = 0;
    prev = dac;
    while (shdn !== 1'b1 && t < 40000) begin
      @(posedge clk_i);
      t++;
      if (dac !== prev) begin
        steps += (dac === prev - 3'h1) ? 1 : 100;
        prev = dac;
      end
    end
    cmpr("fade time", 32740, 32780, t);
    cmpr("fade steps", 7, 7, steps);
    wr(7'h10, 8'h85);
    t = 0;
    while (dac !== 3'h7 && t < 20000) begin
      @(posedge clk_i);
      t++;
    end
    cmpr("ramp time", 14300, 14350, t);
    wr(7'h10, 8'h01);
    pins(8'h3D);
    tally_and_finish;
  end
endmodule
`default_nettype wire
